// File: common/ppl_pkg.sv
// Constants for the per-port PHY link control register bank
package ppl_pkg;
	// ==========================================================
	// Bus widths and port count
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_PHY = 2;

	// ==========================================================
	// Register offsets on the switch register map
	localparam logic [ADDR_W-1:0] OFF_P1_NEG = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_P1_CTLB = 8'h1d;
	localparam logic [ADDR_W-1:0] OFF_P2_NEG = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_P2_CTLB = 8'h2d;
	localparam logic [ADDR_W-1:0] OFF_P3_CTLB = 8'h3d;

	// ==========================================================
	// Negotiation control field positions
	localparam int NEG_AN_EN = 7;
	localparam int NEG_FORCE_SPEED = 6;
	localparam int NEG_FORCE_DUPLEX = 5;
	localparam int NEG_ADV_PAUSE = 4;
	localparam int NEG_ADV_HI = 3;

	// ==========================================================
	// Control B field positions
	localparam int CTLB_LED_OFF = 7;
	localparam int CTLB_TX_DIS = 6;
	localparam int CTLB_RESTART = 5;
	localparam int CTLB_FEF_DIS = 4;
	localparam int CTLB_PWR_DOWN = 3;
	localparam int CTLB_AMDIX_DIS = 2;
	localparam int CTLB_FORCE_MDI = 1;
	localparam int CTLB_LOOPBACK = 0;

	// ==========================================================
	// Reset values and management-view selectors
	localparam logic [DATA_W-1:0] NEG_RESET = 8'hff;
	localparam logic [DATA_W-1:0] CTLB_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	localparam logic MIIM_SEL_NEG = 1'b0;
	localparam logic MIIM_SEL_CTLB = 1'b1;
endpackage

// File: core/ppl_phy_port_link_control_regs.sv
// Per-port PHY link control registers for the two copper ports
`timescale 1ns/10ps
module ppl_phy_port_link_control_regs
	import ppl_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [DATA_W-1:0] regWrData,
	output logic [DATA_W-1:0] regRdData,
	input wire logic miimPort,
	input wire logic miimSel,
	input wire logic miimWrEn,
	input wire logic miimRdEn,
	input wire logic [DATA_W-1:0] miimWrData,
	output logic [DATA_W-1:0] miimRdData,
	input wire logic port1LedOutput0Strap,
	input wire logic port1LedOutput1Strap,
	input wire logic switchMiiRxValidStrap,
	input wire logic switchMiiRxBit3Strap,
	input wire logic switchMiiRxBit2Strap,
	input wire logic switchMiiRxBit1Strap,
	input wire logic [NUM_PHY-1:0] anResolvedSpeed100,
	input wire logic [NUM_PHY-1:0] anResolvedFull,
	input wire logic [NUM_PHY-1:0] anFailed,
	input wire logic [NUM_PHY-1:0] autoMdixDecision,
	input wire logic [NUM_PHY-1:0] ledDrive0,
	input wire logic [NUM_PHY-1:0] ledDrive1,
	output logic [NUM_PHY-1:0] anEnable,
	output logic [NUM_PHY-1:0] anRestart,
	output logic [NUM_PHY-1:0][4:0] advertiseAbility,
	output logic [NUM_PHY-1:0] linkSpeed100,
	output logic [NUM_PHY-1:0] linkFullDuplex,
	output logic [NUM_PHY-1:0] txDisable,
	output logic [NUM_PHY-1:0] farEndFaultDisable,
	output logic [NUM_PHY-1:0] powerDown,
	output logic [NUM_PHY-1:0] mdixMode,
	output logic [NUM_PHY-1:0] loopThroughPhy,
	output logic [NUM_PHY-1:0] portLedOutput0,
	output logic [NUM_PHY-1:0] portLedOutput1
);

	// ==========================================================
	// Strap synchronisers
	// No reset here on purpose: they keep sampling the pins while rst_n is low
	logic [NUM_PHY-1:0][2:0] strapMeta_reg;
	logic [NUM_PHY-1:0][2:0] strapSync_reg;
	logic strapLoaded_reg;
	logic strapLoaded_next;

	always_ff @(posedge clock) begin
		strapMeta_reg <= {{switchMiiRxBit3Strap, switchMiiRxBit2Strap, switchMiiRxBit1Strap},
			{port1LedOutput0Strap, port1LedOutput1Strap, switchMiiRxValidStrap}};
		strapSync_reg <= strapMeta_reg;
	end

	// ==========================================================
	// Control registers
	logic [NUM_PHY-1:0][DATA_W-1:0] neg_reg;
	logic [NUM_PHY-1:0][DATA_W-1:0] neg_next;
	logic [NUM_PHY-1:0][DATA_W-1:0] ctlB_reg;
	logic [NUM_PHY-1:0][DATA_W-1:0] ctlB_next;
	logic [NUM_PHY-1:0] restart_reg;
	logic [NUM_PHY-1:0] restart_next;

	// Write decode; switch map wins over the management view on a collision
	always_comb begin
		logic [ADDR_W-1:0] negOff;
		logic [ADDR_W-1:0] ctlOff;
		logic busNeg;
		logic busCtl;
		logic miiNeg;
		logic miiCtl;
		negOff = OFF_P1_NEG;
		ctlOff = OFF_P1_CTLB;
		busNeg = 1'b0;
		busCtl = 1'b0;
		miiNeg = 1'b0;
		miiCtl = 1'b0;
		neg_next = neg_reg;
		ctlB_next = ctlB_reg;
		restart_next = '0;
		strapLoaded_next = 1'b1;
		for (int p = 0; p < NUM_PHY; p++) begin
			negOff = (p == 0) ? OFF_P1_NEG : OFF_P2_NEG;
			ctlOff = (p == 0) ? OFF_P1_CTLB : OFF_P2_CTLB;
			busNeg = regWrEn && (regAddr == negOff);
			busCtl = regWrEn && (regAddr == ctlOff);
			miiNeg = miimWrEn && (miimPort == p[0]) && (miimSel == MIIM_SEL_NEG);
			miiCtl = miimWrEn && (miimPort == p[0]) && (miimSel == MIIM_SEL_CTLB);
			// First edge after reset release takes the synchronised straps
			if (!strapLoaded_reg) begin
				neg_next[p][NEG_AN_EN:NEG_FORCE_DUPLEX] = strapSync_reg[p];
			end
			if (busNeg) begin
				neg_next[p] = regWrData;
			end else if (miiNeg) begin
				neg_next[p] = miimWrData;
			end
			// Restart bit is a command: it pulses once and reads back zero
			if (busCtl) begin
				ctlB_next[p] = regWrData;
				restart_next[p] = regWrData[CTLB_RESTART];
			end else if (miiCtl) begin
				ctlB_next[p] = miimWrData;
				restart_next[p] = miimWrData[CTLB_RESTART];
			end
			ctlB_next[p][CTLB_RESTART] = 1'b0;
		end
	end

	// Register the control state; writes to the port 3 slot land nowhere
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			neg_reg <= {NUM_PHY{NEG_RESET}};
			ctlB_reg <= {NUM_PHY{CTLB_RESET}};
			restart_reg <= '0;
			strapLoaded_reg <= 1'b0;
		end else begin
			neg_reg <= neg_next;
			ctlB_reg <= ctlB_next;
			restart_reg <= restart_next;
			strapLoaded_reg <= strapLoaded_next;
		end
	end

	// ==========================================================
	// Read paths, one cycle after the read strobe
	logic [DATA_W-1:0] regRd_reg;
	logic [DATA_W-1:0] regRd_next;
	logic [DATA_W-1:0] miimRd_reg;
	logic [DATA_W-1:0] miimRd_next;

	// Unmapped and reserved offsets read as zero
	always_comb begin
		regRd_next = regRd_reg;
		miimRd_next = miimRd_reg;
		if (regRdEn) begin
			unique case (regAddr)
				OFF_P1_NEG: regRd_next = neg_reg[0];
				OFF_P1_CTLB: regRd_next = ctlB_reg[0];
				OFF_P2_NEG: regRd_next = neg_reg[1];
				OFF_P2_CTLB: regRd_next = ctlB_reg[1];
				default: regRd_next = READ_ZERO;
			endcase
		end
		if (miimRdEn) begin
			miimRd_next = (miimSel == MIIM_SEL_NEG) ? neg_reg[miimPort] : ctlB_reg[miimPort];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			regRd_reg <= READ_ZERO;
			miimRd_reg <= READ_ZERO;
		end else begin
			regRd_reg <= regRd_next;
			miimRd_reg <= miimRd_next;
		end
	end

	assign regRdData = regRd_reg;
	assign miimRdData = miimRd_reg;

	// ==========================================================
	// PHY-facing drive, registered so the pins never glitch
	logic [NUM_PHY-1:0] speed_reg;
	logic [NUM_PHY-1:0] speed_next;
	logic [NUM_PHY-1:0] duplex_reg;
	logic [NUM_PHY-1:0] duplex_next;
	logic [NUM_PHY-1:0] mdix_reg;
	logic [NUM_PHY-1:0] mdix_next;
	logic [NUM_PHY-1:0] led0_reg;
	logic [NUM_PHY-1:0] led0_next;
	logic [NUM_PHY-1:0] led1_reg;
	logic [NUM_PHY-1:0] led1_next;
	logic [NUM_PHY-1:0] loop_reg;
	logic [NUM_PHY-1:0] loop_next;

	// Resolve speed, duplex, crossover and LEDs per port
	always_comb begin
		for (int p = 0; p < NUM_PHY; p++) begin
			// Forced speed applies only with negotiation off
			speed_next[p] = neg_reg[p][NEG_AN_EN] ? anResolvedSpeed100[p]
				: neg_reg[p][NEG_FORCE_SPEED];
			// A failed negotiation falls back to the forced duplex
			duplex_next[p] = (neg_reg[p][NEG_AN_EN] && !anFailed[p]) ? anResolvedFull[p]
				: neg_reg[p][NEG_FORCE_DUPLEX];
			// Forced MDI means no crossover, so mdixMode low
			mdix_next[p] = ctlB_reg[p][CTLB_AMDIX_DIS] ? !ctlB_reg[p][CTLB_FORCE_MDI]
				: autoMdixDecision[p];
			// LED pins are active low, so blanking drives them high
			led0_next[p] = ctlB_reg[p][CTLB_LED_OFF] | ledDrive0[p];
			led1_next[p] = ctlB_reg[p][CTLB_LED_OFF] | ledDrive1[p];
			loop_next[p] = ctlB_reg[p][CTLB_LOOPBACK];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			speed_reg <= '1;
			duplex_reg <= '1;
			mdix_reg <= '0;
			led0_reg <= '1;
			led1_reg <= '1;
			loop_reg <= '0;
		end else begin
			speed_reg <= speed_next;
			duplex_reg <= duplex_next;
			mdix_reg <= mdix_next;
			led0_reg <= led0_next;
			led1_reg <= led1_next;
			loop_reg <= loop_next;
		end
	end

	// ==========================================================
	// Direct field outputs
	always_comb begin
		for (int p = 0; p < NUM_PHY; p++) begin
			anEnable[p] = neg_reg[p][NEG_AN_EN];
			advertiseAbility[p] = neg_reg[p][NEG_ADV_PAUSE:0];
			txDisable[p] = ctlB_reg[p][CTLB_TX_DIS];
			farEndFaultDisable[p] = ctlB_reg[p][CTLB_FEF_DIS];
			powerDown[p] = ctlB_reg[p][CTLB_PWR_DOWN];
		end
	end

	assign anRestart = restart_reg;
	assign linkSpeed100 = speed_reg;
	assign linkFullDuplex = duplex_reg;
	assign mdixMode = mdix_reg;
	assign loopThroughPhy = loop_reg;
	assign portLedOutput0 = led0_reg;
	assign portLedOutput1 = led1_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_FORCED_SPEED: assert property (
		!neg_reg[0][NEG_AN_EN] |=> linkSpeed100[0] == $past(neg_reg[0][NEG_FORCE_SPEED]))
		else $error("forced speed not applied");
	AST_FAILED_DUPLEX: assert property (
		(neg_reg[1][NEG_AN_EN] && anFailed[1]) |=> linkFullDuplex[1] == $past(neg_reg[1][NEG_FORCE_DUPLEX]))
		else $error("duplex fallback wrong");
	AST_STRAP_LOAD: assert property (
		!strapLoaded_reg |=> neg_reg[0][NEG_AN_EN] == $past(strapSync_reg[0][2]) || $past(regWrEn || miimWrEn))
		else $error("strap not loaded");
	AST_LED_BLANK: assert property (
		ctlB_reg[0][CTLB_LED_OFF] && ctlB_next[0][CTLB_LED_OFF] |=> portLedOutput0[0] && portLedOutput1[0])
		else $error("led not blanked");
	AST_RESTART_PULSE: assert property (
		regWrEn && regAddr == OFF_P2_CTLB && regWrData[CTLB_RESTART] |=> anRestart[1] ##1 !anRestart[1] || $past(
			regWrEn || miimWrEn))
		else $error("restart pulse wrong");
	AST_RESTART_CLEARS: assert property (
		!ctlB_reg[0][CTLB_RESTART] && !ctlB_reg[1][CTLB_RESTART])
		else $error("restart bit stuck");
	AST_FORCE_MDI: assert property (
		ctlB_reg[0][CTLB_AMDIX_DIS] && ctlB_reg[0][CTLB_FORCE_MDI] |=> !mdixMode[0] || $changed(ctlB_reg[0]))
		else $error("forced MDI not applied");
	AST_RESERVED_SLOT: assert property (
		regRdEn && regAddr == OFF_P3_CTLB |=> regRdData == READ_ZERO)
		else $error("reserved slot not zero");
	AST_TXDIS: assert property (
		regWrEn && regAddr == OFF_P1_CTLB |=> txDisable[0] == $past(regWrData[CTLB_TX_DIS]))
		else $error("tx disable not written");
	AST_MIIM_READ: assert property (
		miimRdEn && miimSel == MIIM_SEL_NEG && !miimPort && !regWrEn && !miimWrEn
			|=> miimRdData == $past(neg_reg[0]))
		else $error("management read wrong");
	COV_FORCED: cover property (!neg_reg[0][NEG_AN_EN] ##1 !linkSpeed100[0]);
	COV_RESTART: cover property (anRestart[1]);
	COV_LOOP: cover property (loopThroughPhy[0] && !loopThroughPhy[1]);
endmodule // ppl_phy_port_link_control_regs

// File: tb/ppl_phy_partner.sv
// Behavioural PHY core and link partner facing the register bank
`timescale 1ns/10ps
module ppl_phy_partner (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] anRestart,
	input wire logic [1:0] cfgSpd,
	input wire logic [1:0] cfgFull,
	input wire logic [1:0] cfgFail,
	input wire logic [1:0] cfgMdix,
	input wire logic [1:0] cfgLed,
	output logic [1:0] anResolvedSpeed100,
	output logic [1:0] anResolvedFull,
	output logic [1:0] anFailed,
	output logic [1:0] autoMdixDecision,
	output logic [1:0] ledDrive0,
	output logic [1:0] ledDrive1
);
	logic [1:0][2:0] busy_reg;
	logic [1:0][2:0] busy_next;
	// ==========================
	// Renegotiation window after a restart pulse
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			busy_next[p] = anRestart[p] ? 3'h4 : (busy_reg[p] != 3'h0 ? busy_reg[p] - 3'h1 : 3'h0);
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= '0;
		end else begin
			busy_reg <= busy_next;
		end
	end
	// Nothing resolved while renegotiating, like a real partner
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			anResolvedSpeed100[p] = (busy_reg[p] == 3'h0) & cfgSpd[p];
			anResolvedFull[p] = (busy_reg[p] == 3'h0) & cfgFull[p];
			anFailed[p] = (busy_reg[p] != 3'h0) | cfgFail[p];
		end
	end
	assign autoMdixDecision = cfgMdix;
	// Both LED pins lit (low) while cfgLed is low, so blanking shows on each
	assign ledDrive0 = cfgLed;
	assign ledDrive1 = cfgLed;
endmodule // ppl_phy_partner

// File: tb/ppl_phy_port_link_control_regs_bench.sv
// Self-checking bench for the PHY link control register bank
`timescale 1ns/10ps
module ppl_phy_port_link_control_regs_bench import ppl_pkg::*;;
	logic clock, rst_n, regWrEn, regRdEn, miimPort, miimSel, miimWrEn, miimRdEn;
	logic [7:0] regAddr, regWrData, miimWrData, regRdData, miimRdData;
	logic [5:0] strap;
	logic [1:0] cfgSpd, cfgFull, cfgFail, cfgMdix, cfgLed, anResolvedSpeed100, anResolvedFull, anFailed;
	logic [1:0] autoMdixDecision, ledDrive0, ledDrive1, anEnable, anRestart, linkSpeed100, linkFullDuplex;
	logic [1:0] txDisable, farEndFaultDisable, powerDown, mdixMode, loopThroughPhy, portLedOutput0, portLedOutput1;
	logic [1:0][4:0] advertiseAbility;
	logic [7:0] nb [2] = '{OFF_P1_NEG, OFF_P2_NEG};
	logic [7:0] cb [2] = '{OFF_P1_CTLB, OFF_P2_CTLB};
	logic [7:0] d;
	int miscompares, check_count, n;
	ppl_phy_port_link_control_regs dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .miimPort(miimPort), .miimSel(miimSel),
		.miimWrEn(miimWrEn), .miimRdEn(miimRdEn), .miimWrData(miimWrData), .miimRdData(miimRdData),
		.port1LedOutput0Strap(strap[0]), .port1LedOutput1Strap(strap[1]), .switchMiiRxValidStrap(strap[2]),
		.switchMiiRxBit3Strap(strap[3]), .switchMiiRxBit2Strap(strap[4]), .switchMiiRxBit1Strap(strap[5]),
		.anResolvedSpeed100(anResolvedSpeed100), .anResolvedFull(anResolvedFull), .anFailed(anFailed),
		.autoMdixDecision(autoMdixDecision), .ledDrive0(ledDrive0), .ledDrive1(ledDrive1), .anEnable(anEnable),
		.anRestart(anRestart), .advertiseAbility(advertiseAbility), .linkSpeed100(linkSpeed100),
		.linkFullDuplex(linkFullDuplex), .txDisable(txDisable), .farEndFaultDisable(farEndFaultDisable),
		.powerDown(powerDown), .mdixMode(mdixMode), .loopThroughPhy(loopThroughPhy),
		.portLedOutput0(portLedOutput0), .portLedOutput1(portLedOutput1));
	ppl_phy_partner partner (.clock(clock), .rst_n(rst_n), .anRestart(anRestart), .cfgSpd(cfgSpd),
		.cfgFull(cfgFull), .cfgFail(cfgFail), .cfgMdix(cfgMdix), .cfgLed(cfgLed),
		.anResolvedSpeed100(anResolvedSpeed100), .anResolvedFull(anResolvedFull), .anFailed(anFailed),
		.autoMdixDecision(autoMdixDecision), .ledDrive0(ledDrive0), .ledDrive1(ledDrive1));
	// ==========================
	// Clock and bus tasks
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic tick(int k = 1);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Strobes drop for a cycle so no signal is set twice in one step
	task automatic wr(logic [7:0] a, logic [7:0] v);
		regAddr = a;
		regWrData = v;
		regWrEn = 1'b1;
		tick();
		regWrEn = 1'b0;
		tick();
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		regAddr = a;
		regRdEn = 1'b1;
		tick();
		regRdEn = 1'b0;
		chk(regRdData, exp);
		tick();
	endtask
	task automatic mrd(logic pt, logic sl, logic [7:0] exp);
		miimPort = pt;
		miimSel = sl;
		miimRdEn = 1'b1;
		tick();
		miimRdEn = 1'b0;
		chk(miimRdData, exp);
		tick();
	endtask
	task automatic mwr(logic pt, logic sl, logic [7:0] v);
		miimPort = pt;
		miimSel = sl;
		miimWrData = v;
		miimWrEn = 1'b1;
		tick();
		miimWrEn = 1'b0;
		tick();
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========================
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		miscompares++;
		close_out();
	end
	// ==========================
	// Test sequence
	initial begin
		{rst_n, regWrEn, regRdEn, miimPort, miimSel, miimWrEn, miimRdEn} = '0;
		{regAddr, regWrData, miimWrData, cfgSpd, cfgFull, cfgFail, cfgMdix, cfgLed} = '0;
		strap = 6'b010101;
		repeat (6) @(posedge clock);
		#1 rst_n = 1'b1;
		tick(2);
		rd(nb[0], 8'hbf);
		rd(nb[1], 8'h5f);
		rd(cb[0], CTLB_RESET);
		chk(8'(anEnable), 8'h01);
		chk(8'({linkSpeed100[1], linkFullDuplex[1]}), 8'h02);
		wr(OFF_P3_CTLB, 8'hff);
		rd(OFF_P3_CTLB, READ_ZERO);
		rd(8'h50, READ_ZERO);
		$display("reset and reserved test done");
		for (int p = 0; p < 2; p++) begin
			// Forced speed and duplex, all four combinations
			for (int i = 0; i < 4; i++) begin
				wr(nb[p], {1'b0, 2'(i), 5'h1f});
				chk(8'({anEnable[p], linkSpeed100[p], linkFullDuplex[p]}), 8'(i));
			end
			// Negotiation on but failed: duplex forced, speed resolved
			cfgFail[p] = 1'b1;
			cfgSpd[p] = 1'b1;
			wr(nb[p], 8'h9f);
			tick(2);
			chk(8'({linkSpeed100[p], linkFullDuplex[p]}), 8'h02);
			cfgFail[p] = 1'b0;
			cfgFull[p] = 1'b1;
			tick(2);
			chk(8'(linkFullDuplex[p]), 8'h01);
			for (int i = 0; i < 5; i++) begin
				d = 8'h9f ^ 8'(1 << i);
				wr(nb[p], d);
				chk(8'(advertiseAbility[p]), 8'(d[4:0]));
				rd(nb[p], d);
			end
			// Single control bits, LEDs normally on
			for (int b = 0; b < 8; b++) begin
				if (b != 5) begin
					wr(cb[p], 8'(1 << b));
					chk(8'({portLedOutput1[p], portLedOutput0[p], txDisable[p], farEndFaultDisable[p],
						powerDown[p], loopThroughPhy[p]}), {2'b0, {2{b == 7}}, b == 6, b == 4, b == 3,
						b == 0});
					rd(cb[p], 8'(1 << b));
				end
			end
			// Crossover table: auto follows partner, forced ignores it
			for (int j = 0; j < 4; j++) begin
				cfgMdix[p] = (j < 2);
				wr(cb[p], j == 1 ? 8'h06 : (j == 2 ? 8'h04 : 8'h00));
				chk(8'(mdixMode[p]), 8'(j == 0 || j == 2));
			end
			// Unblanked LED pins follow the link logic
			cfgLed[p] = 1'b1;
			tick(2);
			chk(8'({portLedOutput1[p], portLedOutput0[p]}), 8'h03);
			cfgLed[p] = 1'b0;
			// Restart gives exactly one pulse and reads back zero
			regAddr = cb[p];
			regWrData = 8'h20;
			regWrEn = 1'b1;
			tick();
			regWrEn = 1'b0;
			n = 0;
			repeat (3) begin
				n += anRestart[p];
				tick();
			end
			chk(8'(n), 8'h01);
			rd(cb[p], 8'h00);
			mwr(p[0], MIIM_SEL_CTLB, 8'h40);
			rd(cb[p], 8'h40);
			mrd(p[0], MIIM_SEL_CTLB, 8'h40);
			mwr(p[0], MIIM_SEL_NEG, 8'h7f);
			rd(nb[p], 8'h7f);
			mrd(p[0], MIIM_SEL_NEG, 8'h7f);
			wr(cb[p], 8'h00);
			$display("port %0d test done", p + 1);
		end
		// Mid-run reset with the opposite straps reloads bits 7:5
		strap = 6'b101010;
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(2);
		rd(nb[0], 8'h5f);
		rd(nb[1], 8'hbf);
		rd(cb[1], CTLB_RESET);
		$display("second reset test done");
		close_out();
	end
endmodule // ppl_phy_port_link_control_regs_bench
